// *** core/master_counter.v ***
// master channel: reloading interval down-counter
`timescale 1ns/1ps
`default_nettype none
module master_counter #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         start,
    input  wire         stop,
    input  wire [W-1:0] period,
    output reg          run_reg,
    output reg  [W-1:0] cnt_reg,
    output reg          irq_reg
);
    // --------------------------------------------------------------
    // interval counting
    // --------------------------------------------------------------
    // start raises the irq at once and loads the period
    always @(posedge clk) begin
        if (rst) begin
            run_reg <= 1'b0;
            cnt_reg <= {W{1'b0}};
            irq_reg <= 1'b0;
        end else if (stop) begin
            run_reg <= 1'b0;                 // counter keeps value
            irq_reg <= 1'b0;
        end else if (start) begin
            run_reg <= 1'b1;
            cnt_reg <= period;
            irq_reg <= 1'b1;
        end else if (run_reg && cnt_reg == {W{1'b0}}) begin
            cnt_reg <= period;               // reload same cycle
            irq_reg <= 1'b1;
        end else begin
            if (run_reg) begin
                cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
            end
            irq_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** core/mpwm_regs.vh ***
// constants for the multi-channel pwm unit
`ifndef MPWM_REGS_VH
`define MPWM_REGS_VH
`define MPWM_CNT_W        16
`define MPWM_CNT_ZERO     16'h0000
`define MPWM_CNT_RST      16'h0000
`define MPWM_SLAVES_UNIT0 7
`define MPWM_SLAVES_UNIT1 3
`define MPWM_CLK_PERIOD_NS 5
`endif

// *** core/multi_channel_pwm_unit.v ***
// top of the multi-channel pwm unit: master, slaves and pin logic
`timescale 1ns/1ps
`default_nettype none
`include "mpwm_regs.vh"

// Function
// RULE1 - start triggers self-clear; enable status flags set to one
// RULE2 - master irq raised at start and triggers every slave
// RULE3 - master loads period, counts down, reloads and irqs at zero
// RULE4 - slave 1 loads duty on master irq, irqs at zero, halts
// RULE5 - slave pin active one clock after master irq, inactive at zero
// RULE6 - slave 2 and later behave exactly like slave 1
// RULE7 - output period is period value plus one count clocks
// RULE8 - duty is duty over period plus one; larger means 100 percent
// RULE9 - unit 0 up to seven slaves, unit 1 up to three
// RULE10 - software leaves mode, output mode and level alone while running
// RULE11 - software updates period and duty right after a master irq
// RULE12 - live counter values readable at any time
// RULE13 - stop triggers clear status; counters and pin levels held
// RULE14 - with output enable clear, pin follows software level bit
// RULE15 - software sets output enable before restart only
// RULE16 - software parks pin in port mode before power down
// RULE17 - power enable clear resets all logic and outputs to zero
// RULE18 - output level and enable writes accepted while running
// RULE19 - level bit zero active high, one active low
// RULE20 - mode bit one selects combination set and reset operation
// RULE21 - slaves sit above their master and follow only its irq
module multi_channel_pwm_unit #(
    parameter W      = `MPWM_CNT_W,
    parameter NSLAVE = `MPWM_SLAVES_UNIT0  // [RULE9] unit 1 uses 3
) (
    input  wire                MCLK,
    input  wire                RST,
    input  wire                POWER_ENABLE,
    input  wire [NSLAVE:0]     CHAN_START_TRIGGER,
    input  wire [NSLAVE:0]     CHAN_STOP_TRIGGER,
    input  wire [W-1:0]        PERIOD_DATA_VALUE,
    input  wire [NSLAVE*W-1:0] DUTY_DATA_VALUE,
    input  wire [NSLAVE-1:0]   SLAVE_OUT_ENABLE,
    input  wire [NSLAVE-1:0]   OUT_MODE_BIT,
    input  wire [NSLAVE-1:0]   OUT_LEVEL_BIT,
    input  wire [NSLAVE-1:0]   SW_OUT_VALUE,
    output wire [NSLAVE:0]     CHAN_ENABLE_STATUS,
    output wire [NSLAVE:0]     CHAN_TRIGGER_PENDING,
    output wire [W-1:0]        MASTER_COUNTER,
    output wire [NSLAVE*W-1:0] SLAVE_COUNTER,
    output wire                MASTER_PERIOD_IRQ,
    output wire [NSLAVE-1:0]   SLAVE_DUTY_IRQ,
    output reg  [NSLAVE-1:0]   SLAVE_PWM_OUT,
    output reg  [NSLAVE-1:0]   SLAVE_PIN_OE
);
    // --------------------------------------------------------------
    // reset and power gating
    // --------------------------------------------------------------
    // powering off resets every channel exactly like the reset pin
    wire unit_rst;
    assign unit_rst = RST | ~POWER_ENABLE;           // [RULE17]

    // triggers are single-cycle write pulses; reading them back
    // always shows zero because they clear themselves
    assign CHAN_TRIGGER_PENDING = {(NSLAVE+1){1'b0}}; // [RULE1]

    // --------------------------------------------------------------
    // master channel
    // --------------------------------------------------------------
    wire m_run;
    wire m_irq;
    // master is channel 0; slaves follow as channels 1..NSLAVE
    master_counter #(.W(W)) u_master (
        .clk     (MCLK),
        .rst     (unit_rst),
        .start   (CHAN_START_TRIGGER[0]),    // [RULE1] [RULE2]
        .stop    (CHAN_STOP_TRIGGER[0]),     // [RULE13]
        .period  (PERIOD_DATA_VALUE),        // [RULE3] [RULE7]
        .run_reg (m_run),
        .cnt_reg (MASTER_COUNTER),           // [RULE12]
        .irq_reg (m_irq)
    );
    assign MASTER_PERIOD_IRQ     = m_irq;
    assign CHAN_ENABLE_STATUS[0] = m_run;

    // --------------------------------------------------------------
    // slave channels
    // --------------------------------------------------------------
    wire [NSLAVE-1:0] s_active;
    wire [NSLAVE-1:0] s_run;
    wire [NSLAVE-1:0] s_busy;

    // every slave listens only to this master's irq
    genvar i;
    generate
        for (i = 0; i < NSLAVE; i = i + 1) begin : g_slave
            slave_counter #(.W(W)) u_slave (
                .clk        (MCLK),
                .rst        (unit_rst),
                .start      (CHAN_START_TRIGGER[i+1]), // [RULE1]
                .stop       (CHAN_STOP_TRIGGER[i+1]),  // [RULE13]
                .trig       (m_irq),                   // [RULE21] [RULE2]
                .duty       (DUTY_DATA_VALUE[i*W +: W]), // [RULE4] [RULE6]
                .run_reg    (s_run[i]),
                .busy_reg   (s_busy[i]),
                .cnt_reg    (SLAVE_COUNTER[i*W +: W]),   // [RULE12]
                .irq_reg    (SLAVE_DUTY_IRQ[i]),
                .active_reg (s_active[i])                // [RULE5]
            );
            assign CHAN_ENABLE_STATUS[i+1] = s_run[i];
        end
    endgenerate

    // --------------------------------------------------------------
    // pin logic
    // --------------------------------------------------------------
    // next value of a slave's active flag, mirroring slave_counter;
    // the pin flop takes it so the pin moves on the counter's own edge
    // instead of one clock behind it
    function next_active;
        input         run;
        input         start;
        input         stop;
        input         trig;
        input         busy;
        input         cur;
        input [W-1:0] duty;
        input [W-1:0] cnt;
        begin
            if (stop) begin
                next_active = cur;
            end else if ((run || start) && trig) begin
                next_active = (duty != {W{1'b0}});
            end else if (busy && cnt == {{(W-1){1'b0}}, 1'b1}) begin
                next_active = 1'b0;
            end else begin
                next_active = cur;
            end
        end
    endfunction

    // a duty above period+1 never reaches zero before the next
    // master irq reloads it, so the pin stays active: 100 percent
    // [RULE8]
    integer k;
    always @(posedge MCLK) begin
        if (unit_rst) begin
            SLAVE_PWM_OUT <= {NSLAVE{1'b0}};               // [RULE17]
            SLAVE_PIN_OE  <= {NSLAVE{1'b0}};
        end else begin
            for (k = 0; k < NSLAVE; k = k + 1) begin
                SLAVE_PIN_OE[k] <= 1'b1;
                if (SLAVE_OUT_ENABLE[k] && OUT_MODE_BIT[k]) begin
                    // combination mode: master sets, slave resets
                    SLAVE_PWM_OUT[k] <= OUT_LEVEL_BIT[k] ^ next_active(
                        s_run[k], CHAN_START_TRIGGER[k+1],
                        CHAN_STOP_TRIGGER[k+1], m_irq, s_busy[k],
                        s_active[k], DUTY_DATA_VALUE[k*W +: W],
                        SLAVE_COUNTER[k*W +: W]);          // [RULE5]
                end else begin
                    // software level drives the pin; used after stop
                    SLAVE_PWM_OUT[k] <= SW_OUT_VALUE[k];     // [RULE14]
                end
            end
        end
    end
    // mode, enable and level are taken live each cycle  [RULE18]
    // polarity inversion above  [RULE19] [RULE20]
endmodule
`default_nettype wire

// *** core/slave_counter.v ***
// slave channel: one-count down-counter timing the active width
`timescale 1ns/1ps
`default_nettype none
module slave_counter #(
    parameter W = 16
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         start,
    input  wire         stop,
    input  wire         trig,
    input  wire [W-1:0] duty,
    output reg          run_reg,
    output reg          busy_reg,
    output reg  [W-1:0] cnt_reg,
    output reg          irq_reg,
    output reg          active_reg
);
    // --------------------------------------------------------------
    // one-count operation
    // --------------------------------------------------------------
    // trigger loads duty; at zero the width ends and we wait.
    // duty of zero gives no active cycle at all (0% output)
    always @(posedge clk) begin
        if (rst) begin
            run_reg    <= 1'b0;
            busy_reg   <= 1'b0;
            cnt_reg    <= {W{1'b0}};
            irq_reg    <= 1'b0;
            active_reg <= 1'b0;
        end else if (stop) begin
            run_reg  <= 1'b0;                // value and level held
            busy_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end else begin
            if (start) begin
                run_reg <= 1'b1;
            end
            irq_reg <= 1'b0;
            if ((run_reg || start) && trig) begin
                cnt_reg    <= duty;
                busy_reg   <= (duty != {W{1'b0}});
                active_reg <= (duty != {W{1'b0}});
            end else if (busy_reg) begin
                if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                    cnt_reg    <= {W{1'b0}};
                    busy_reg   <= 1'b0;
                    active_reg <= 1'b0;
                    irq_reg    <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/mpwm_assertions.sv ***
// checker for the multi-channel pwm unit ports
`timescale 1ns/1ps
`default_nettype none
module mpwm_assertions #(
    parameter W      = 16,
    parameter NSLAVE = 7
) (
    input wire logic                MCLK,
    input wire logic                RST,
    input wire logic                POWER_ENABLE,
    input wire logic [NSLAVE:0]     CHAN_START_TRIGGER,
    input wire logic [NSLAVE:0]     CHAN_STOP_TRIGGER,
    input wire logic [W-1:0]        PERIOD_DATA_VALUE,
    input wire logic [NSLAVE*W-1:0] DUTY_DATA_VALUE,
    input wire logic [NSLAVE:0]     CHAN_ENABLE_STATUS,
    input wire logic [NSLAVE:0]     CHAN_TRIGGER_PENDING,
    input wire logic [W-1:0]        MASTER_COUNTER,
    input wire logic [NSLAVE*W-1:0] SLAVE_COUNTER,
    input wire logic                MASTER_PERIOD_IRQ,
    input wire logic [NSLAVE-1:0]   SLAVE_DUTY_IRQ,
    input wire logic [NSLAVE-1:0]   SLAVE_OUT_ENABLE,
    input wire logic [NSLAVE-1:0]   OUT_MODE_BIT,
    input wire logic [NSLAVE-1:0]   OUT_LEVEL_BIT,
    input wire logic [NSLAVE-1:0]   SLAVE_PWM_OUT
);
    default clocking @(posedge MCLK); endclocking
    // power-down counts as reset of the whole unit
    default disable iff (RST || !POWER_ENABLE);
    // joint start of master and slave 1, then the first irq
    sequence s_go;
        CHAN_START_TRIGGER[1:0] == 2'h3 && !CHAN_STOP_TRIGGER[1:0]
        ##1 MASTER_PERIOD_IRQ;
    endsequence
    // slave 1 one count from the end, not retriggered
    sequence s_last;
        CHAN_ENABLE_STATUS[1] && SLAVE_COUNTER[W-1:0] == 1
        && !MASTER_PERIOD_IRQ && !CHAN_STOP_TRIGGER[1];
    endsequence
    start_flags_a: assert property (
        CHAN_START_TRIGGER[0] && !CHAN_STOP_TRIGGER[0] |=>
        CHAN_ENABLE_STATUS[0] && MASTER_PERIOD_IRQ
        && MASTER_COUNTER == $past(PERIOD_DATA_VALUE)) else $error("start");
    slave_start_a: assert property (
        s_go |=> CHAN_ENABLE_STATUS[1]
        && SLAVE_COUNTER[W-1:0] == $past(DUTY_DATA_VALUE[W-1:0]))
        else $error("slave start");
    trig_clear_a: assert property (
        CHAN_TRIGGER_PENDING == '0) else $error("trigger stuck");
    master_reload_a: assert property (
        CHAN_ENABLE_STATUS[0] && MASTER_COUNTER == 0
        && !CHAN_STOP_TRIGGER[0] |=> MASTER_PERIOD_IRQ
        && MASTER_COUNTER == $past(PERIOD_DATA_VALUE)) else $error("reload");
    count_down_a: assert property (
        CHAN_ENABLE_STATUS[0] && MASTER_COUNTER != 0 && !CHAN_START_TRIGGER[0]
        && !CHAN_STOP_TRIGGER[0] |=> !MASTER_PERIOD_IRQ
        && MASTER_COUNTER == $past(MASTER_COUNTER) - 1) else $error("count");
    stop_hold_a: assert property (
        CHAN_STOP_TRIGGER[0] |=> !CHAN_ENABLE_STATUS[0]
        && $stable(MASTER_COUNTER)) else $error("stop");
    idle_hold_a: assert property (
        !CHAN_ENABLE_STATUS[0] && !CHAN_START_TRIGGER[0] |=>
        $stable(MASTER_COUNTER) && !MASTER_PERIOD_IRQ) else $error("idle");
    slave_two_a: assert property (
        MASTER_PERIOD_IRQ && CHAN_ENABLE_STATUS[2] && !CHAN_STOP_TRIGGER[2]
        |=> SLAVE_COUNTER[2*W-1:W] == $past(DUTY_DATA_VALUE[2*W-1:W]))
        else $error("slave two");
    duty_irq_a: assert property (
        s_last |=> SLAVE_DUTY_IRQ[0] && SLAVE_COUNTER[W-1:0] == 0)
        else $error("duty irq");
    slave_halt_a: assert property (
        SLAVE_DUTY_IRQ[0] && !MASTER_PERIOD_IRQ |=> !SLAVE_DUTY_IRQ[0]
        && SLAVE_COUNTER[W-1:0] == 0) else $error("halt");
    // pin goes active on the edge the slave loads its duty
    pin_active_a: assert property (
        MASTER_PERIOD_IRQ && CHAN_ENABLE_STATUS[1] && !CHAN_STOP_TRIGGER[1]
        && DUTY_DATA_VALUE[W-1:0] != 0
        && SLAVE_OUT_ENABLE[0] && OUT_MODE_BIT[0]
        |=> SLAVE_PWM_OUT[0] != $past(OUT_LEVEL_BIT[0]))
        else $error("pin on");
    // pin goes inactive on the edge the slave count reaches zero
    pin_off_a: assert property (
        s_last ##0 (SLAVE_OUT_ENABLE[0] && OUT_MODE_BIT[0])
        |=> SLAVE_PWM_OUT[0] == $past(OUT_LEVEL_BIT[0]))
        else $error("pin off");
endmodule
bind multi_channel_pwm_unit mpwm_assertions #(.W(W), .NSLAVE(NSLAVE)) chk_inst (
    .MCLK(MCLK), .RST(RST), .POWER_ENABLE(POWER_ENABLE),
    .CHAN_START_TRIGGER(CHAN_START_TRIGGER),
    .CHAN_STOP_TRIGGER(CHAN_STOP_TRIGGER),
    .PERIOD_DATA_VALUE(PERIOD_DATA_VALUE), .DUTY_DATA_VALUE(DUTY_DATA_VALUE),
    .CHAN_ENABLE_STATUS(CHAN_ENABLE_STATUS),
    .CHAN_TRIGGER_PENDING(CHAN_TRIGGER_PENDING),
    .MASTER_COUNTER(MASTER_COUNTER), .SLAVE_COUNTER(SLAVE_COUNTER),
    .MASTER_PERIOD_IRQ(MASTER_PERIOD_IRQ), .SLAVE_DUTY_IRQ(SLAVE_DUTY_IRQ),
    .SLAVE_OUT_ENABLE(SLAVE_OUT_ENABLE), .OUT_MODE_BIT(OUT_MODE_BIT),
    .OUT_LEVEL_BIT(OUT_LEVEL_BIT), .SLAVE_PWM_OUT(SLAVE_PWM_OUT));
`default_nettype wire

// *** tb/pwm_load_model.sv ***
// load on one pwm pin: counts the cycles it is driven high
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input  wire logic clk,
    input  wire logic clr,
    input  wire logic pin,
    output var  int   hi
);
    // unknown levels never count as high
    always @(posedge clk) begin
        if (clr) begin
            hi <= 0;
        end else begin
            hi <= hi + int'(pin === 1'b1);
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_multi_channel_pwm_unit.sv ***
// self-checking bench for the multi-channel pwm unit
`timescale 1ns/1ps
`default_nettype none
module tb_multi_channel_pwm_unit;
    localparam logic [15:0] P = 16'h0004;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        pe = 1'b1;
    logic        clr = 1'b0;
    logic [2:0]  st = 3'h0, sp = 3'h0;
    logic [31:0] duty = 32'h0007_0002;
    logic [1:0]  oe = 2'h3, md = 2'h3, lvl = 2'h0, sw = 2'h0;
    logic [15:0] hold;
    wire  [2:0]  stat, pend;
    wire  [15:0] mcnt;
    wire  [31:0] scnt;
    wire         mirq;
    wire  [1:0]  sirq, pin, poe;
    int          hi1, hi2, bad_count = 0, checked = 0;
    always #2.5 mclk = ~mclk;
    multi_channel_pwm_unit #(.W(16), .NSLAVE(2)) multi_channel_pwm_unit_inst (
        .MCLK(mclk), .RST(rst), .POWER_ENABLE(pe), .CHAN_START_TRIGGER(st),
        .CHAN_STOP_TRIGGER(sp), .PERIOD_DATA_VALUE(P), .DUTY_DATA_VALUE(duty),
        .SLAVE_OUT_ENABLE(oe), .OUT_MODE_BIT(md), .OUT_LEVEL_BIT(lvl),
        .SW_OUT_VALUE(sw), .CHAN_ENABLE_STATUS(stat),
        .CHAN_TRIGGER_PENDING(pend), .MASTER_COUNTER(mcnt),
        .SLAVE_COUNTER(scnt), .MASTER_PERIOD_IRQ(mirq),
        .SLAVE_DUTY_IRQ(sirq), .SLAVE_PWM_OUT(pin), .SLAVE_PIN_OE(poe));
    pwm_load_model load1_inst (.clk(mclk), .clr(clr), .pin(pin[0]), .hi(hi1));
    pwm_load_model load2_inst (.clk(mclk), .clr(clr), .pin(pin[1]), .hi(hi2));
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // triggers are one-cycle pulses, as software bits that self-clear
    task automatic trig(input logic [2:0] s, p);
        @(posedge mclk); st <= s; sp <= p;
        @(posedge mclk); st <= 3'h0; sp <= 3'h0;
        #1;
    endtask
    // five whole periods, so the window phase does not matter
    task automatic meas(input int e1, e2);
        @(posedge mclk); clr <= 1'b1;
        @(posedge mclk); clr <= 1'b0;
        repeat (5 * (P + 1)) @(posedge mclk);
        #1;
        chk("pin1 high", e1, hi1);
        chk("pin2 high", e2, hi2);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        cyc(5);
        rst <= 1'b0;
        #1;
        chk("reset", 4'h0, {pin, poe});
        trig(3'h7, 3'h0);
        chk("start", {3'h7, P, 1'b1}, {stat, mcnt, mirq});
        cyc(6);
        meas(10, 25);
        trig(3'h0, 3'h7);
        hold = mcnt;
        chk("stop", 3'h0, stat);
        cyc(3);
        oe <= 2'h0;
        sw <= 2'h2;
        cyc(2);
        #1;
        chk("held count", hold, mcnt);
        chk("sw level", 2'h2, pin);
        chk("pin oe", 2'h3, poe);
        // enable and polarity set while stopped; slave 2 enable cleared again after the restart
        oe <= 2'h3;
        lvl <= 2'h1;
        trig(3'h7, 3'h0);
        cyc(1);
        oe <= 2'h1;
        cyc(6);
        meas(15, 25);
        // new duty written just after a master irq, one period to settle
        @(posedge mclk iff mirq);
        duty <= 32'h0007_0003;
        cyc(5);
        meas(10, 25);
        cyc(1);
        md <= 2'h0;
        sw <= 2'h3;
        cyc(2);
        #1;
        chk("mode off", 2'h3, pin);
        cyc(1);
        pe <= 1'b0;
        cyc(2);
        #1;
        chk("power off", 23'h0, {stat, mcnt, pin, poe});
        chk("power off slaves", 32'h0, scnt);
        complete_run;
    end
    // watchdog well beyond the expected run of about 130 cycles
    initial begin
        #3000;
        bad_count++;
        complete_run;
    end
endmodule
`default_nettype wire
